// ### include/bpc_pkg.sv
// Purpose: Shared constants and types for the branch and predication control block.
// Assumes: 16-bit narrow encodings for compare-and-branch and the predicate block instruction.
// Notes: Table branches are presented as pre-decoded operation requests.
package bpc_pkg;

  // Condition codes; the always condition is 4'he.
  localparam logic [3:0] BPC_COND_ALWAYS = 4'h_e;
  localparam logic [3:0] BPC_COND_EQ = 4'h_0;

  // Core register numbers with special meaning.
  localparam logic [3:0] BPC_REG_SP = 4'h_d;
  localparam logic [3:0] BPC_REG_PC = 4'h_f;

  // Compare-and-branch reach in bytes past the instruction address.
  localparam logic [31:0] BPC_CB_MIN_OFS = 32'h_0000_0004;
  localparam logic [31:0] BPC_CB_MAX_OFS = 32'h_0000_0082;

  // Length of a narrow instruction and the read-ahead of the pc operand.
  localparam logic [31:0] BPC_INSTR_LEN = 32'h_0000_0002;
  localparam logic [31:0] BPC_PC_AHEAD = 32'h_0000_0004;
  localparam logic [31:0] BPC_WIDE_LEN = 32'h_0000_0004;

  // Predication state after reset.
  localparam logic [7:0] BPC_PRED_RESET = 8'h_00;

  // Decoded operation classes, one-hot.
  typedef enum logic [7:0] {
    BPC_OP_NONE = 8'b0000_0001,
    BPC_OP_CBZ = 8'b0000_0010,
    BPC_OP_BRANCH_IF_NONZERO = 8'b0000_0100,
    BPC_OP_PRED = 8'b0000_1000,
    BPC_OP_TBB = 8'b0001_0000,
    BPC_OP_TBH = 8'b0010_0000,
    BPC_OP_BRK = 8'b0100_0000,
    BPC_OP_IRQ = 8'b1000_0000
  } bpc_op_t;

  // Table branch sequencing, one-hot.
  typedef enum logic [2:0] {
    BPC_ST_IDLE = 3'b001,
    BPC_ST_FETCH = 3'b010,
    BPC_ST_JUMP = 3'b100
  } bpc_state_t;

endpackage

// ### design/bpc_pred_state.sv
// Purpose: Holds predication state: base condition plus shifting slot mask.
// Assumes: One slot advance per completed instruction.
// Notes: State is the 8-bit form saved in the stacked status word.
`timescale 1ns/100ps
module bpc_pred_state (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic reset_i,
  // Control.
  input wire logic load_i,
  input wire logic [7:0] load_val_i,
  input wire logic advance_i,
  input wire logic restore_i,
  input wire logic [7:0] restore_val_i,
  // State.
  output logic [7:0] state_o,
  output logic in_block_o,
  output logic last_slot_o,
  output logic [3:0] slot_cond_o
);
  import bpc_pkg::*;

  logic [7:0] state_reg;
  logic [7:0] state_next;
  logic [7:0] adv_val;

  // Advancing shifts the mask left; an empty mask clears the whole state.
  assign adv_val = (state_reg[2:0] == 3'h_0) ? BPC_PRED_RESET : {state_reg[7:5], state_reg[4:0] << 1};
  // Restore from an exception return beats a plain advance.
  assign state_next = restore_i ? restore_val_i :
                      load_i ? load_val_i :
                      advance_i ? adv_val : state_reg;
  assign state_o = state_reg;
  assign in_block_o = (state_reg[3:0] != 4'h_0);
  assign last_slot_o = (state_reg[3:0] == 4'h_8);
  assign slot_cond_o = state_reg[7:4];

  // State register.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_reg <= BPC_PRED_RESET;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule // bpc_pred_state

// ### design/bpc_branch_ctrl.sv
// Purpose: Compare-and-branch, predicate block and table branch control.
// Assumes: Instruction arrives with its address, register file reads are combinational.
// Notes: Table entries are read over a simple one-request memory port.
`timescale 1ns/100ps

// How it works
// - Branch-if-zero jumps when register equals zero.
// - Branch-if-nonzero jumps when register is nonzero.
// - Tested register is a three-bit low selector.
// - Compare-branch targets lie 4 to 130 forward.
// - Predicate block covers one to four instructions.
// - Each slot switch picks condition or inverse.
// - Breakpoint in a block always executes.
// - Exceptions save return address and predication state.
// - Exception return restores remaining slot conditions.
// - Predicate, compare-branch, irq toggles illegal inside.
// - Pc writers allowed only in final slot.
// - Conditionals except plain branch need a block.
// - Predicate instruction leaves flags untouched.
// - Byte table branch jumps twice unsigned byte.
// - Pc base means table follows instruction.
// - Reject stack pointer base, sp/pc index.
// - Link-writing branches store instruction address plus four.
module bpc_branch_ctrl (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic reset_i,
  // Decoded instruction.
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [31:0] instr_addr_i,
  input wire logic is_tbb_i,
  input wire logic is_tbh_i,
  input wire logic [3:0] tb_base_sel_i,
  input wire logic [3:0] tb_index_sel_i,
  input wire logic is_irq_toggle_i,
  input wire logic is_breakpoint_i,
  input wire logic writes_pc_i,
  input wire logic is_plain_bcond_i,
  input wire logic has_cond_i,
  input wire logic link_write_i,
  input wire logic instr_done_i,
  // Register file read values.
  input wire logic [31:0] rn_val_i,
  input wire logic [31:0] tb_base_val_i,
  input wire logic [31:0] tb_index_val_i,
  // Condition evaluation of the current slot.
  input wire logic cond_pass_i,
  // Exception entry and return.
  input wire logic exc_entry_i,
  input wire logic exc_return_i,
  input wire logic [7:0] exc_pred_i,
  // Table memory port.
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  output logic mem_req_o,
  output logic [31:0] mem_addr_o,
  output logic mem_half_o,
  // Register selector for the compare-branch operand.
  output logic [2:0] rn_sel_o,
  // Branch outputs.
  output logic branch_o,
  output logic [31:0] branch_target_o,
  output logic link_we_o,
  output logic [31:0] link_val_o,
  // Predication outputs.
  output logic [3:0] slot_cond_o,
  output logic in_block_o,
  output logic exec_slot_o,
  output logic [7:0] stacked_pred_o,
  output logic [31:0] stacked_ret_o,
  output logic flags_hold_o,
  output logic illegal_o,
  output logic busy_o
);
  import bpc_pkg::*;

  // Decoded class of the current instruction and the table branch sequencer state.
  bpc_op_t op;
  bpc_state_t state_reg;
  bpc_state_t state_next;

  // Narrow-encoding decode of the compare-branch and predicate block instruction.
  // Compare-branch is 1011 o 0 i 1 imm5 rn, with o set for the nonzero form; the predicate
  // instruction is 1011 1111 cond mask, and a zero mask belongs to other hint encodings.
  // Table branches arrive as wide instructions and come pre-decoded on their own inputs.
  function automatic logic is_cb(input logic [15:0] w);
    is_cb = (w[15:12] == 4'h_b) && (w[10] == 1'b0) && (w[8] == 1'b1);
  endfunction

  function automatic logic is_pred(input logic [15:0] w);
    is_pred = (w[15:8] == 8'h_bf) && (w[3:0] != 4'h_0);
  endfunction

  // Hits of the current instruction word and of the table branch pre-decode levels.
  wire cb_hit = is_cb(instr_i);
  wire pred_hit = is_pred(instr_i);
  wire tb_hit = is_tbb_i | is_tbh_i;

  // Operation class; table branches and breakpoints come pre-decoded.
  // Compare-branch and predicate decode come first, so a stray pre-decode level cannot hide them.
  always_comb begin
    op = BPC_OP_NONE;
    if (cb_hit) begin
      op = instr_i[11] ? BPC_OP_BRANCH_IF_NONZERO : BPC_OP_CBZ;
    end else if (pred_hit) begin
      op = BPC_OP_PRED;
    end else if (is_tbb_i) begin
      op = BPC_OP_TBB;
    end else if (is_tbh_i) begin
      op = BPC_OP_TBH;
    end else if (is_breakpoint_i) begin
      op = BPC_OP_BRK;
    end else if (is_irq_toggle_i) begin
      op = BPC_OP_IRQ;
    end
  end

  // Predication state keeper.
  // It is loaded by the predicate instruction, advanced by each completed slot and reloaded
  // from the stacked copy on an exception return, which is the only way into a block mid-way.
  logic [7:0] pred_state;
  logic pred_in_block;
  logic pred_last;
  logic [3:0] pred_cond;
  logic pred_load;
  logic pred_adv;

  bpc_pred_state u_pred (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .load_i(pred_load),
    .load_val_i(instr_i[7:0]),
    .advance_i(pred_adv),
    .restore_i(exc_return_i),
    .restore_val_i(exc_pred_i),
    .state_o(pred_state),
    .in_block_o(pred_in_block),
    .last_slot_o(pred_last),
    .slot_cond_o(pred_cond)
  );

  // An always base with any else switch is refused. A switch at mask bit n exists only while a
  // lower mask bit still marks a later slot, and it means else when it differs from cond[0].
  wire [3:0] mask = instr_i[3:0];
  wire [2:0] else_bits;
  genvar gi;
  generate
    for (gi = 1; gi < 4; gi = gi + 1) begin : g_sw
      // A switch is present when a lower mask bit still marks a later slot.
      assign else_bits[gi-1] = (mask[gi-1:0] != '0) && (mask[gi] != instr_i[4]);
    end
  endgenerate
  wire pred_bad_always = pred_hit && (instr_i[7:4] == BPC_COND_ALWAYS) && (else_bits != 3'h_0);

  // Legality checks inside and outside a predicated block.
  // A refused instruction still reaches the decode stage, which must discard it on illegal_o.
  // Pc writers are checked against the live slot, not against the trailing in_block_o mirror.
  wire in_blk_forbidden = pred_in_block &&
                          (cb_hit || pred_hit || is_irq_toggle_i);
  wire pc_not_last = pred_in_block && !pred_last && (writes_pc_i || tb_hit);
  wire cond_outside = !pred_in_block && has_cond_i && !is_plain_bcond_i;
  wire tb_bad_regs = tb_hit && ((tb_base_sel_i == BPC_REG_SP) ||
                     (tb_index_sel_i == BPC_REG_SP) || (tb_index_sel_i == BPC_REG_PC));
  wire illegal_now = instr_valid_i && (in_blk_forbidden || pc_not_last || cond_outside ||
                     tb_bad_regs || pred_bad_always);

  // Slot execution: breakpoints run regardless of the slot condition.
  // Outside a block every instruction executes; the condition input only matters inside one.
  wire slot_exec = !pred_in_block || cond_pass_i || (op == BPC_OP_BRK);

  // Compare-and-branch target: offset i:imm5:'0' from the read-ahead pc.
  // The offset is even and at most 126, so the target lies 4 to 130 bytes ahead and never behind.
  wire [6:0] cb_ofs = {instr_i[9], instr_i[7:3], 1'b0};
  wire [31:0] cb_target = instr_addr_i + BPC_PC_AHEAD + {25'h_0, cb_ofs};
  wire cb_zero = (rn_val_i == 32'h_0000_0000);
  wire cb_take = (op == BPC_OP_CBZ) ? cb_zero : !cb_zero;
  wire cb_fire = instr_valid_i && cb_hit && !illegal_now && (state_reg == BPC_ST_IDLE);

  // Table address: pc base means the byte after the wide instruction.
  // With the pc as base the table starts right after the wide table branch instruction.
  // A halfword table scales the index by two; the top index bit is lost, a limit of the 32-bit sum.
  wire [31:0] tb_base = (tb_base_sel_i == BPC_REG_PC) ?
                        (instr_addr_i + BPC_WIDE_LEN) : tb_base_val_i;
  wire [31:0] tb_addr = is_tbh_i ? (tb_base + {tb_index_val_i[30:0], 1'b0}) :
                        (tb_base + tb_index_val_i);
  wire tb_start = instr_valid_i && tb_hit && !illegal_now && slot_exec &&
                  (state_reg == BPC_ST_IDLE);

  // Registers that hold a table branch in flight.
  // The entry is zero-extended, so the jump is forward only, at most twice the largest entry.
  logic [31:0] tb_next_pc_reg;
  logic tb_half_reg;
  logic [31:0] mem_addr_reg;
  logic mem_req_reg;
  wire [15:0] tb_entry = tb_half_reg ? mem_rdata_i : {8'h_00, mem_rdata_i[7:0]};
  wire [31:0] tb_target = tb_next_pc_reg + {15'h_0, tb_entry, 1'b0};

  // Table branch sequencer.
  // Idle takes a start, fetch waits for the memory answer and jump spends the cycle of the branch.
  // Only one table branch can be in flight; busy_o tells the fetch stage to hold the next one.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BPC_ST_IDLE: begin
        if (tb_start) begin
          state_next = BPC_ST_FETCH;
        end
      end
      BPC_ST_FETCH: begin
        if (mem_ack_i) begin
          state_next = BPC_ST_JUMP;
        end
      end
      BPC_ST_JUMP: begin
        state_next = BPC_ST_IDLE;
      end
      default: begin
        state_next = BPC_ST_IDLE;
      end
    endcase
  end

  // Predication load and advance. An exception between slots simply freezes the state, so the
  // stacked copy taken on entry still names the slot that was interrupted.
  assign pred_load = instr_valid_i && pred_hit && !illegal_now && !exc_entry_i;
  assign pred_adv = instr_done_i && pred_in_block && !pred_hit && !exc_entry_i;

  // Next values of the registered outputs. A table branch answer and a compare-branch cannot meet,
  // because a compare-branch only fires while the sequencer is idle.
  wire branch_next = (cb_fire && cb_take && slot_exec) ||
                     ((state_reg == BPC_ST_FETCH) && mem_ack_i);
  wire [31:0] target_next = (state_reg == BPC_ST_FETCH) ? tb_target : cb_target;
  wire link_next = instr_valid_i && link_write_i && slot_exec && !illegal_now;
  // Compare-branch, predicate and table branch never touch the flags; the flag logic elsewhere
  // only lets an in-block instruction that asks for it change them.
  wire flags_hold_next = instr_valid_i && (cb_hit || pred_hit || tb_hit);
  // Busy looks one state ahead so that it is high in every cycle that the sequencer is not idle.
  wire busy_next = (state_next != BPC_ST_IDLE);

  // Sequencer state and the table request; the request stays up until the memory answers.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_reg <= BPC_ST_IDLE;
      mem_req_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      mem_req_reg <= tb_start || (mem_req_reg && !mem_ack_i);
    end
  end

  // Table branch operands, captured once at the start so that the instructions behind it
  // cannot disturb the fetch or the jump.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tb_next_pc_reg <= 32'h_0000_0000;
      tb_half_reg <= 1'b0;
      mem_addr_reg <= 32'h_0000_0000;
    end else if (tb_start) begin
      tb_next_pc_reg <= instr_addr_i + BPC_WIDE_LEN;
      tb_half_reg <= is_tbh_i;
      mem_addr_reg <= tb_addr;
    end
  end

  // Branch request and its target. The target register also moves when no branch is asked;
  // only branch_o qualifies it.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      branch_o <= 1'b0;
      branch_target_o <= 32'h_0000_0000;
    end else begin
      branch_o <= branch_next;
      branch_target_o <= target_next;
    end
  end

  // Link write; the value is the address of the next instruction. Every link-writing form is
  // taken to be a wide instruction, which is a limitation for the narrow register forms.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      link_we_o <= 1'b0;
      link_val_o <= 32'h_0000_0000;
    end else begin
      link_we_o <= link_next;
      link_val_o <= instr_addr_i + BPC_WIDE_LEN;
    end
  end

  // Status pulses for the decode stage; an illegal instruction has no other effect.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      illegal_o <= 1'b0;
      flags_hold_o <= 1'b0;
      exec_slot_o <= 1'b0;
    end else begin
      illegal_o <= illegal_now;
      flags_hold_o <= flags_hold_next;
      exec_slot_o <= instr_valid_i && slot_exec;
    end
  end

  // Exception capture: return address and live predication state. Both stand until the next entry,
  // so a nested entry overwrites them; the handler must stack them first.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      stacked_pred_o <= BPC_PRED_RESET;
      stacked_ret_o <= 32'h_0000_0000;
    end else if (exc_entry_i) begin
      stacked_pred_o <= pred_state;
      stacked_ret_o <= instr_addr_i;
    end
  end

  // Predication mirrors, registered so every output comes from a flip-flop. They trail the
  // internal state by one cycle, which the decode stage must allow for.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      slot_cond_o <= 4'h_0;
      in_block_o <= 1'b0;
    end else begin
      slot_cond_o <= pred_cond;
      in_block_o <= pred_in_block;
    end
  end

  // Busy flag and the operand selector of the compare-branch.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      busy_o <= 1'b0;
      rn_sel_o <= 3'h_0;
    end else begin
      busy_o <= busy_next;
      rn_sel_o <= instr_i[2:0];
    end
  end

  // The memory port comes straight from its registers.
  assign mem_req_o = mem_req_reg;
  assign mem_addr_o = mem_addr_reg;
  assign mem_half_o = tb_half_reg;
endmodule // bpc_branch_ctrl

// ### test/bpc_branch_ctrl_checker.sv
// Purpose: Port assertions for the branch and predication control block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Instruction antecedents, except the in-block compare-branch check, skip cycles with a table branch in flight.
`timescale 1ns/100ps
module bpc_branch_ctrl_checker import bpc_pkg::*; (
  // Clock, reset and requests.
  input wire logic clock_i, reset_i, instr_valid_i, is_tbb_i, is_tbh_i, writes_pc_i, link_write_i, mem_ack_i,
  input wire logic [15:0] instr_i,
  input wire logic [31:0] instr_addr_i, rn_val_i, tb_base_val_i, tb_index_val_i,
  input wire logic [3:0] tb_base_sel_i, tb_index_sel_i,
  // Design outputs.
  input wire logic mem_req_o, mem_half_o, branch_o, link_we_o, in_block_o, flags_hold_o, illegal_o, busy_o,
  input wire logic [2:0] rn_sel_o,
  input wire logic [31:0] mem_addr_o, branch_target_o, link_val_o
);
  // Compare-branch decode and table address; the offset field can only reach forward.
  wire logic cb = instr_i[15:12] == 4'hb && !instr_i[10] && instr_i[8];
  wire logic [31:0] ofs = {25'h0, instr_i[9], instr_i[7:3], 1'b0};
  wire logic cb_go = instr_valid_i && cb && !in_block_o && !busy_o;
  wire logic tb_go = instr_valid_i && (is_tbb_i || is_tbh_i) && !in_block_o && !busy_o;
  wire logic tb_bad = tb_base_sel_i == BPC_REG_SP || tb_index_sel_i == BPC_REG_SP || tb_index_sel_i == BPC_REG_PC;
  wire logic [31:0] tb_base = tb_base_sel_i == BPC_REG_PC ? instr_addr_i + BPC_WIDE_LEN : tb_base_val_i;
  wire logic [31:0] tb_addr = tb_base + (is_tbh_i ? tb_index_val_i << 1 : tb_index_val_i);
  default clocking cb_clk @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // A table fetch waiting, and its answer.
  sequence s_wait; mem_req_o && !mem_ack_i; endsequence
  sequence s_done; mem_req_o && mem_ack_i; endsequence
  chk_cbz_taken: assert property (cb_go && !instr_i[11] && rn_val_i == 32'h0 |=> branch_o &&
    branch_target_o == $past(instr_addr_i) + BPC_PC_AHEAD + $past(ofs)) else $error("Zero branch wrong.");
  chk_branch_if_nonzero_taken: assert property (cb_go && instr_i[11] && rn_val_i != 32'h0 |=> branch_o &&
    branch_target_o == $past(instr_addr_i) + BPC_PC_AHEAD + $past(ofs)) else $error("Nonzero branch wrong.");
  chk_cb_skip: assert property (cb_go && (instr_i[11] == (rn_val_i == 32'h0)) |=> !branch_o)
    else $error("Compare branch taken wrongly.");
  chk_cb_select: assert property (cb_go |=> flags_hold_o && rn_sel_o == $past(instr_i[2:0]))
    else $error("Selector or flags wrong.");
  chk_cb_in_block: assert property (instr_valid_i && cb && in_block_o |=> illegal_o && !branch_o)
    else $error("Compare branch in block kept.");
  chk_tb_fetch: assert property (tb_go && !tb_bad |=> mem_req_o && busy_o &&
    mem_half_o == $past(is_tbh_i) && mem_addr_o == $past(tb_addr)) else $error("Table fetch wrong.");
  chk_tb_reject: assert property (tb_go && tb_bad |=> illegal_o && !mem_req_o)
    else $error("Bad table registers taken.");
  chk_req_hold: assert property (s_wait |=> mem_req_o) else $error("Table request dropped.");
  chk_tb_jump: assert property (s_done |=> branch_o ##1 !busy_o) else $error("Table jump missing.");
  chk_link_next: assert property (instr_valid_i && link_write_i && writes_pc_i && !in_block_o && !busy_o |=>
    link_we_o && link_val_o == $past(instr_addr_i) + 32'h4) else $error("Link value wrong.");
endmodule // bpc_branch_ctrl_checker
bind bpc_branch_ctrl bpc_branch_ctrl_checker chk_u (.*);

// ### test/testbench.sv
// Purpose: Self-checking bench for the branch and predication control block.
// Assumes: Answers one cycle after the taking edge, levels settle two cycles after a slot step.
// Notes: Compare-branch cases run from a table; blocks and table branches are hand-written.
`timescale 1ns/100ps
module testbench;
  import bpc_pkg::*;
  typedef struct packed {logic [15:0] w; logic [31:0] rv; logic br; logic [31:0] ofs;} bpc_row_t;
  // Encoding, operand, taken, distance from the instruction; both reach limits included.
  localparam bpc_row_t ROWS [5] = '{'{16'hb103, 32'h0, 1'b1, 32'h4}, '{16'hb3ff, 32'h0, 1'b1, 32'h82},
    '{16'hb100, 32'h1, 1'b0, 32'h0}, '{16'hb92d, 32'h8000_0000, 1'b1, 32'he}, '{16'hb901, 32'h0, 1'b0, 32'h0}};
  logic clock_i = 1'b0, reset_i = 1'b1, instr_valid_i = 1'b0, cond_pass_i = 1'b1, mem_ack_i = 1'b0;
  logic instr_done_i = 1'b0, exc_entry_i = 1'b0, exc_return_i = 1'b0, is_plain_bcond_i = 1'b0, has_cond_i = 1'b0;
  logic is_tbb_i = 1'b0, is_tbh_i = 1'b0, is_irq_toggle_i = 1'b0, is_breakpoint_i = 1'b0, writes_pc_i = 1'b0;
  logic link_write_i = 1'b0;
  logic [15:0] instr_i = 16'h0, mem_rdata_i = 16'h0;
  logic [31:0] instr_addr_i = 32'h0, rn_val_i = 32'h0, tb_base_val_i = 32'h0, tb_index_val_i = 32'h0;
  logic [3:0] tb_base_sel_i = 4'h0, tb_index_sel_i = 4'h0;
  logic [7:0] exc_pred_i = 8'h0;
  logic mem_req_o, mem_half_o, branch_o, link_we_o, in_block_o, exec_slot_o, flags_hold_o, illegal_o, busy_o;
  logic [2:0] rn_sel_o;
  logic [3:0] slot_cond_o;
  logic [7:0] stacked_pred_o;
  logic [31:0] mem_addr_o, branch_target_o, link_val_o, stacked_ret_o;
  int n_fail = 0, samples_checked = 0, cycles = 0;
  bpc_branch_ctrl dut_u (.*);
  // Clock at 8 ns; a hang ends in the report because the whole run needs fewer than a hundred cycles.
  always #4 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      close_out();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task do_reset;
    reset_i <= 1'b1;
    tick(10);
    reset_i <= 1'b0;
  endtask
  // One instruction for one cycle with its pre-decode levels; returns just after the answer edge.
  task go(input logic [15:0] w, input logic [5:0] f, input logic [31:0] a);
    @(posedge clock_i);
    instr_valid_i <= 1'b1;
    instr_i <= w;
    instr_addr_i <= a;
    {is_tbb_i, is_tbh_i, is_irq_toggle_i, is_breakpoint_i, writes_pc_i, link_write_i} <= f;
    @(posedge clock_i);
    instr_valid_i <= 1'b0;
    instr_i <= 16'h0;
    {is_tbb_i, is_tbh_i, is_irq_toggle_i, is_breakpoint_i, writes_pc_i, link_write_i} <= 6'h0;
    #1;
  endtask
  task done;
    @(posedge clock_i);
    instr_done_i <= 1'b1;
    @(posedge clock_i);
    instr_done_i <= 1'b0;
    tick(2);
  endtask
  task exc(input logic ret);
    @(posedge clock_i);
    {exc_return_i, exc_entry_i} <= {ret, ~ret};
    @(posedge clock_i);
    {exc_return_i, exc_entry_i} <= 2'b00;
    tick(2);
  endtask
  // Table branch with a slow memory; the data bus carries junk outside the answer cycle.
  task tb_run(input logic [3:0] bs, input logic [31:0] bv, input logic [5:0] f, input logic [15:0] d,
    input logic [31:0] ea, input logic [31:0] et);
    tb_base_sel_i <= bs;
    tb_base_val_i <= bv;
    go(16'h0, f, 32'h3000);
    chk(mem_addr_o, ea);
    chk(mem_half_o, f[4]);
    chk(busy_o, 1'b1);
    tick(2);
    chk(mem_req_o, 1'b1);
    mem_ack_i <= 1'b1;
    mem_rdata_i <= d;
    @(posedge clock_i);
    mem_ack_i <= 1'b0;
    mem_rdata_i <= ~d;
    #1;
    chk(branch_target_o, et);
    chk(branch_o, 1'b1);
  endtask
  task close_out;
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Table cases first, then blocks, exceptions, table branches and a second reset.
  initial begin
    do_reset();
    foreach (ROWS[k]) begin
      rn_val_i <= ROWS[k].rv;
      go(ROWS[k].w, 6'h0, 32'h1000 + 32'(k) * 32'h100);
      chk(branch_o, ROWS[k].br);
      if (ROWS[k].br) chk(branch_target_o, 32'h1000 + 32'(k) * 32'h100 + ROWS[k].ofs);
      chk(rn_sel_o, ROWS[k].w[2:0]);
    end
    go(16'hbfec, 6'h0, 32'h2000);
    chk(illegal_o, 1'b1);
    go(16'hbf0c, 6'h0, 32'h2000);
    chk(flags_hold_o, 1'b1);
    tick(2);
    chk(slot_cond_o, BPC_COND_EQ);
    chk(in_block_o, 1'b1);
    go(16'hb100, 6'h0, 32'h2002);
    chk(illegal_o, 1'b1);
    go(16'h0, 6'b001000, 32'h2002);
    chk(illegal_o, 1'b1);
    cond_pass_i <= 1'b0;
    go(16'h0, 6'b000100, 32'h2002);
    chk(exec_slot_o, 1'b1);
    cond_pass_i <= 1'b1;
    done();
    chk(slot_cond_o, 4'h1);
    instr_addr_i <= 32'h2004;
    exc(1'b0);
    chk(stacked_pred_o, 8'h18);
    chk(stacked_ret_o, 32'h2004);
    exc_pred_i <= 8'h0c;
    exc(1'b1);
    chk({in_block_o, slot_cond_o}, 5'h10);
    go(16'h0, 6'b000010, 32'h2006);
    chk(illegal_o, 1'b1);
    done();
    go(16'h0, 6'b000010, 32'h2008);
    chk(illegal_o, 1'b0);
    done();
    chk(in_block_o, 1'b0);
    has_cond_i <= 1'b1;
    go(16'h0, 6'h0, 32'h5000);
    chk(illegal_o, 1'b1);
    is_plain_bcond_i <= 1'b1;
    go(16'h0, 6'h0, 32'h5002);
    chk(illegal_o, 1'b0);
    {has_cond_i, is_plain_bcond_i} <= 2'b00;
    tb_index_sel_i <= 4'h2;
    tb_index_val_i <= 32'h3;
    tb_run(BPC_REG_PC, 32'h0, 6'b100000, 16'h77a5, 32'h3007, 32'h314e);
    tb_run(4'h4, 32'h4000, 6'b010000, 16'h8001, 32'h4006, 32'h13006);
    tb_base_sel_i <= BPC_REG_SP;
    go(16'h0, 6'b100000, 32'h3000);
    chk(illegal_o, 1'b1);
    tb_base_sel_i <= 4'h4;
    tb_index_sel_i <= BPC_REG_PC;
    go(16'h0, 6'b010000, 32'h3000);
    chk(mem_req_o, 1'b0);
    go(16'h0, 6'b000011, 32'h6000);
    chk(link_val_o, 32'h6004);
    chk(link_we_o, 1'b1);
    do_reset();
    chk(in_block_o, 1'b0);
    close_out();
  end
endmodule // testbench
